// ---- rtl/abx_core.sv ----
`timescale 1ns/10ps
`include "abx_params.svh"
module abx_core #(
   parameter int AW = `ABX_FILE_AW,
   parameter int PW = `ABX_PC_W
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Instruction issue
   input wire logic issue,
   input wire abx_pkg::abx_op_t op,
   input wire logic [AW-1:0] file_addr,
   input wire logic dest_sel,
   input wire logic [2:0] bit_sel,
   input wire logic [`ABX_OFS_W-1:0] branch_ofs,
   // Architectural state
   output logic [7:0] acc,
   output logic carry_flag,
   output logic digit_carry_flag,
   output logic zero_flag,
   output logic [PW-1:0] program_counter,
   output logic busy
);
   import abx_pkg::*;

   // Offset width, kept local so the extension below reads plainly
   localparam int OW = `ABX_OFS_W;

   // Data memory, one word per file address
   logic [7:0] mem [0:(1<<AW)-1];

   // Accumulator and its next value
   logic [7:0] acc_r;
   logic [7:0] acc_nxt;

   // Status flags and their next values
   logic c_r;
   logic c_nxt;
   logic dc_r;
   logic dc_nxt;
   logic z_r;
   logic z_nxt;

   // Program counter and its next value
   logic [PW-1:0] pc_r;
   logic [PW-1:0] pc_nxt;

   // Sequencer state
   abx_state_t st_r;
   abx_state_t st_nxt;

   // Opcode decode; undefined codes only advance the counter
   wire is_add = (op == ABX_OP_ADD);
   wire is_addc = (op == ABX_OP_ADDC);
   wire is_asr = (op == ABX_OP_ASR);
   wire is_bclr = (op == ABX_OP_BCLR);
   wire is_btsc = (op == ABX_OP_BTSC);
   wire is_bra = (op == ABX_OP_BRA);
   wire is_sum = is_add || is_addc;
   wire is_alu = is_sum || is_asr; // Ops that yield an 8-bit result

   // Issue qualification; the second cycle of a slow op is a dead slot
   wire in_run = (st_r == ABX_ST_RUN);
   wire go = clk_en && issue && in_run;
   wire go_sum = go && is_sum;
   wire go_asr = go && is_asr;
   wire go_alu = go && is_alu;

   // File operand and the chosen bit
   wire [7:0] fop = mem[file_addr];
   wire [7:0] bit_mask = 8'h01 << bit_sel;
   wire bit_val = fop[bit_sel];

   // Adder; low nibble summed apart so its carry gives the digit carry
   wire cin = is_addc ? c_r : 1'b0;
   wire [4:0] lo_sum = {1'b0, acc_r[3:0]} + {1'b0, fop[3:0]} + {4'h0, cin};
   wire [8:0] full_sum = {1'b0, acc_r} + {1'b0, fop} + {8'h00, cin};
   wire [7:0] sum_res = full_sum[7:0];
   wire sum_c = full_sum[8];
   wire sum_dc = lo_sum[4];

   // Shifter; the sign bit repeats so signed values halve correctly
   wire [7:0] shr = {fop[7], fop[7:1]};
   wire shr_c = fop[0];

   // Bit clear; only the masked bit falls
   wire [7:0] bclr = fop & ~bit_mask;

   // Result select and zero test
   wire [7:0] result = is_sum ? sum_res : shr;
   wire res_zero = (result == 8'h00);

   // Destination routing; bit clear always writes back to the file
   wire wr_acc = go_alu && !dest_sel;
   wire wr_file = go && ((is_alu && dest_sel) || is_bclr);
   wire [7:0] file_wdata = is_bclr ? bclr : result;

   // Two-cycle decision; a set tested bit keeps the skip test to one cycle
   wire skip = is_btsc && !bit_val;
   wire slow = is_bra || skip;

   // Counter arithmetic; offset sign-extended to counter width, wraps silently
   wire [PW-1:0] pc_inc = pc_r + {{(PW-1){1'b0}}, 1'b1};
   wire [PW-1:0] ofs_ext = {{(PW-OW){branch_ofs[OW-1]}}, branch_ofs};
   wire [PW-1:0] pc_bra = pc_inc + ofs_ext;

   // Next accumulator
   assign acc_nxt = wr_acc ? result : acc_r;

   // Next carry: adds and the shift write it, all else keeps it
   assign c_nxt = go_sum ? sum_c : (go_asr ? shr_c : c_r);

   // Next digit carry; the shift leaves it alone
   assign dc_nxt = go_sum ? sum_dc : dc_r;

   // Next zero flag; bit ops, skips and branches keep it
   assign z_nxt = go_alu ? res_zero : z_r;

   // Next counter; branch target or plain increment
   assign pc_nxt = go ? (is_bra ? pc_bra : pc_inc) : pc_r;

   // State for the two-cycle instructions
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         ABX_ST_RUN: begin
            if (go && slow) begin
               st_nxt = ABX_ST_NOP;
            end
         end
         ABX_ST_NOP: begin
            if (clk_en) begin
               st_nxt = ABX_ST_RUN;
            end
         end
         default: st_nxt = ABX_ST_RUN;
      endcase
   end

   // Data memory has no reset; plain always so a bench may preload words
   always @(posedge clk) begin
      if (wr_file) begin
         mem[file_addr] <= file_wdata;
      end
   end

   // Sequencer state
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= ABX_ST_RUN;
      end else if (clk_en) begin
         st_r <= st_nxt;
      end
   end

   // Accumulator
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         acc_r <= `ABX_ACC_RST;
      end else if (clk_en) begin
         acc_r <= acc_nxt;
      end
   end

   // Carry flag
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         c_r <= 1'b0;
      end else if (clk_en) begin
         c_r <= c_nxt;
      end
   end

   // Digit carry flag
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dc_r <= 1'b0;
      end else if (clk_en) begin
         dc_r <= dc_nxt;
      end
   end

   // Zero flag
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         z_r <= 1'b0;
      end else if (clk_en) begin
         z_r <= z_nxt;
      end
   end

   // Program counter
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pc_r <= `ABX_PC_RST;
      end else if (clk_en) begin
         pc_r <= pc_nxt;
      end
   end

   // Outputs straight from the registers

   assign acc = acc_r;
   assign carry_flag = c_r;
   assign digit_carry_flag = dc_r;
   assign zero_flag = z_r;
   assign program_counter = pc_r;
   assign busy = (st_r == ABX_ST_NOP); // Second cycle acts as no-op
endmodule : abx_core

// ---- rtl/abx_params.svh ----
`ifndef ABX_PARAMS_SVH
`define ABX_PARAMS_SVH
`define ABX_FILE_AW 7
`define ABX_FILE_MAX 127
`define ABX_PC_W 15
`define ABX_OFS_W 9
`define ABX_ACC_RST 8'h00
`define ABX_PC_RST 15'h0000
`define ABX_SLOW_CYCLES 2
`endif

// ---- rtl/abx_pkg.sv ----
package abx_pkg;
   typedef enum logic [2:0] {
      ABX_OP_ADD = 3'h0,
      ABX_OP_ADDC = 3'h1,
      ABX_OP_ASR = 3'h2,
      ABX_OP_BCLR = 3'h3,
      ABX_OP_BTSC = 3'h4,
      ABX_OP_BRA = 3'h5
   } abx_op_t;
   typedef enum logic [0:0] {
      ABX_ST_RUN = 1'b0,
      ABX_ST_NOP = 1'b1
   } abx_state_t;
endpackage : abx_pkg

// ---- tb/abx_core_asserts.sv ----
`timescale 1ns/10ps
module abx_chk import abx_pkg::*; #(parameter int PW = 15) (
   // Issue side
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic issue,
   input wire logic dest_sel,
   input wire logic busy,
   input wire abx_pkg::abx_op_t op,
   input wire logic [8:0] branch_ofs,
   // State
   input wire logic [7:0] acc,
   input wire logic carry_flag,
   input wire logic digit_carry_flag,
   input wire logic zero_flag,
   input wire logic [PW-1:0] program_counter
);
   // Taken op, flags, branch target
   wire tk = clk_en && issue && !busy;
   wire [2:0] fl = {carry_flag, digit_carry_flag, zero_flag};
   wire wa = tk && op inside {ABX_OP_ADD, ABX_OP_ADDC, ABX_OP_ASR};
   wire [PW-1:0] tgt = program_counter + PW'(1) + PW'($signed(branch_ofs));
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_bra_target: assert property (tk && op == ABX_OP_BRA |=> program_counter == $past(tgt))
      else $error("bad target");
   a_bra_busy: assert property (tk && op == ABX_OP_BRA |=> busy) else $error("no busy");
   a_busy_one: assert property (busy && clk_en |=> !busy) else $error("long busy");
   a_flags_kept: assert property (tk && op inside {ABX_OP_BRA, ABX_OP_BTSC, ABX_OP_BCLR}
      |=> $stable(fl)) else $error("flags moved");
   a_bclr_acc: assert property (tk && op == ABX_OP_BCLR |=> $stable(acc))
      else $error("acc moved");
   a_file_dest: assert property (wa && dest_sel |=> $stable(acc)) else $error("acc hit");
   a_zero_match: assert property (wa && !dest_sel |=> zero_flag == (acc == 8'h00))
      else $error("bad zero");
   a_asr_sign: assert property (tk && op == ABX_OP_ASR && !dest_sel |=> acc[7] == acc[6])
      else $error("bad sign");
   // Main scenarios
   cover property (tk && op == ABX_OP_BTSC ##1 busy);
   cover property (wa && dest_sel);
   cover property (tk && op == ABX_OP_BRA);
   cover property (busy && issue);
endmodule : abx_chk

// ---- tb/tb_abx_core.sv ----
`timescale 1ns/10ps
module tb_abx_core;
   import abx_pkg::*;
   // Drive and observe
   logic clk = 0, rst_b = 0, clk_en = 1, issue = 0, dest_sel = 0, bz;
   abx_op_t op = ABX_OP_ADD;
   logic [6:0] file_addr = 7'h00;
   logic [2:0] bit_sel = 3'h0;
   logic [8:0] branch_ofs = 9'h000;
   logic [7:0] acc;
   logic carry_flag, digit_carry_flag, zero_flag, busy;
   logic [14:0] program_counter, bp;
   wire [2:0] fl = {carry_flag, digit_carry_flag, zero_flag};
   int n_errors = 0, comparisons = 0, cyc = 0;
   abx_core abx_core_inst (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .issue(issue), .op(op),
      .file_addr(file_addr), .dest_sel(dest_sel), .bit_sel(bit_sel), .branch_ofs(branch_ofs),
      .acc(acc), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
      .zero_flag(zero_flag), .program_counter(program_counter), .busy(busy));
   initial forever #5 clk = ~clk;
   // Hang guard, far above the few dozen cycles needed
   always @(posedge clk) if (++cyc == 500) begin
      n_errors++;
      end_of_test();
   end
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // One op, then a spare cycle so a busy slot passes
   task automatic run(abx_op_t o, logic [6:0] f, logic d, logic [2:0] b, logic [8:0] k);
      op = o;
      {file_addr, dest_sel, bit_sel, branch_ofs, issue} = {f, d, b, k, 1'b1};
      @(negedge clk) issue = 0;
      {bz, bp} = {busy, program_counter};
      @(negedge clk);
   endtask : run
   task automatic t_add;
      abx_core_inst.mem[5] = 8'h88;
      run(ABX_OP_ADD, 7'h05, 1'b0, 3'h0, 9'h000);
      chk("acc", 16'h0088, acc);
      run(ABX_OP_ADD, 7'h05, 1'b0, 3'h0, 9'h000);
      chk("flags", 16'h0006, fl);
      run(ABX_OP_ADDC, 7'h05, 1'b1, 3'h0, 9'h000);
      chk("file", 16'h0099, abx_core_inst.mem[5]);
      chk("acc", 16'h0010, acc);
   endtask : t_add
   task automatic t_shift_clear;
      run(ABX_OP_ASR, 7'h05, 1'b0, 3'h0, 9'h000);
      chk("acc", 16'h00CC, acc);
      run(ABX_OP_BCLR, 7'h05, 1'b0, 3'h7, 9'h000);
      chk("file", 16'h0019, abx_core_inst.mem[5]);
      chk("flags", 16'h0004, fl);
      abx_core_inst.mem[6] = 8'h34;
      run(ABX_OP_ADD, 7'h06, 1'b0, 3'h0, 9'h000);
      chk("flags", 16'h0007, fl);
   endtask : t_shift_clear
   task automatic t_skip_branch;
      run(ABX_OP_BRA, 7'h00, 1'b0, 3'h0, 9'h1FE);
      chk("pc", 16'h0005, bp);
      run(ABX_OP_BTSC, 7'h05, 1'b0, 3'h7, 9'h000);
      chk("busy", 16'h0001, bz);
      run(ABX_OP_BTSC, 7'h05, 1'b0, 3'h0, 9'h000);
      chk("busy", 16'h0000, bz);
   endtask : t_skip_branch
   // Issue in the dead slot, then with the enable low: both must vanish
   task automatic t_refuse_freeze;
      op = ABX_OP_BRA;
      {file_addr, dest_sel, branch_ofs, issue} = {7'h06, 1'b0, 9'h000, 1'b1};
      @(negedge clk) op = ABX_OP_ADD;
      @(negedge clk) issue = 0;
      chk("acc", 16'h0000, acc);
      chk("pc", 16'h0008, program_counter);
      clk_en = 0;
      run(ABX_OP_ADD, 7'h06, 1'b0, 3'h0, 9'h000);
      chk("acc", 16'h0000, acc);
      chk("pc", 16'h0008, program_counter);
      clk_en = 1;
   endtask : t_refuse_freeze
   // Reset in mid-run; memory keeps its words, first issue right after release
   task automatic t_reset_mid;
      rst_b = 0;
      @(negedge clk);
      chk("flags", 16'h0000, fl);
      chk("pc", 16'h0000, program_counter);
      rst_b = 1;
      run(ABX_OP_ADD, 7'h06, 1'b0, 3'h0, 9'h000);
      chk("acc", 16'h0034, acc);
      chk("pc", 16'h0001, program_counter);
   endtask : t_reset_mid
   task automatic end_of_test;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (4) @(negedge clk);
      rst_b = 1;
      t_add();
      t_shift_clear();
      t_skip_branch();
      t_refuse_freeze();
      t_reset_mid();
      end_of_test();
   end
endmodule : tb_abx_core
bind abx_core abx_chk #(.PW(PW)) abx_chk_inst (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
   .issue(issue), .dest_sel(dest_sel), .busy(busy), .op(op), .branch_ofs(branch_ofs),
   .acc(acc), .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
   .zero_flag(zero_flag), .program_counter(program_counter));
